// File: rtl/altfn_pkg.sv
// Package: shared types and constants for the Port B / Port C override logic.
// Assumes a single 125 MHz system clock domain.
package altfn_pkg;

  localparam int unsigned CLK_PERIOD_PS     = 8000;
  localparam int unsigned SPIKE_REJECT_PS   = 50000;
  // Least time: round up to whole cycles, at least one
  localparam int unsigned SPIKE_REJECT_CYC  =
    ((SPIKE_REJECT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ? 1 :
    ((SPIKE_REJECT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  localparam int unsigned PORTB_WIDTH       = 8;
  localparam logic [7:0]  PORTB_RESET       = 8'h00;
  localparam logic [1:0]  PORTC_RESET       = 2'h0;
  localparam int unsigned PB_CAPTURE        = 0;
  localparam int unsigned PB_MATCH_A        = 1;
  localparam int unsigned PB_SELECT         = 2;
  localparam int unsigned PB_MOSI           = 3;
  localparam int unsigned PB_MISO           = 4;
  localparam int unsigned PB_SCK            = 5;
  localparam int unsigned PB_OSC1           = 6;
  localparam int unsigned PB_OSC2           = 7;

  // Per-pin override bundle
  typedef struct packed {
    logic pullup_ovr_enable;
    logic pullup_ovr_value;
    logic direction_ovr_enable;
    logic direction_ovr_value;
    logic pin_value_ovr_enable;
    logic pin_value_ovr_value;
    logic input_gate_ovr_enable;
    logic input_gate_ovr_value;
  } pin_ovr_t;

  // Resolved pad controls of one pin
  typedef struct packed {
    logic pullup_on;
    logic drive_en;
    logic drive_val;
    logic input_en;
  } pad_ctl_t;

  // SPI side of Port B
  typedef struct packed {
    logic serial_periph_on;
    logic spi_leader_role;
    logic sck_out;
    logic leader_data_out;
    logic follower_data_out;
  } spi_ctl_t;

  typedef struct packed {
    logic sck_in;
    logic leader_data_in;
    logic follower_data_in;
    logic select_active;
  } spi_in_t;

  // Timer side of Port B
  typedef struct packed {
    logic timer1_match_a_en;
    logic timer1_match_a_out;
    logic timer1_match_b_en;
    logic timer1_match_b_out;
    logic timer2_match_en;
    logic timer2_match_out;
  } timer_ctl_t;

  // Clock source and reset fuses
  typedef struct packed {
    logic onchip_rc_selected;
    logic outside_clock_selected;
    logic timer2_async_select;
    logic reset_pin_disable_fuse;
  } clk_cfg_t;

  // Pad control from the port bits and override signals
  function automatic pad_ctl_t resolve_pad(
    input pin_ovr_t ovr,
    input logic     dir_bit,
    input logic     out_bit,
    input logic     global_pullup_off
  );
    pad_ctl_t p;
    p.drive_en  = ovr.direction_ovr_enable ? ovr.direction_ovr_value
                                           : dir_bit;
    p.drive_val = ovr.pin_value_ovr_enable ? ovr.pin_value_ovr_value
                                           : out_bit;
    p.pullup_on = ovr.pullup_ovr_enable ? ovr.pullup_ovr_value
                : (!dir_bit && out_bit && !global_pullup_off);
    p.input_en  = ovr.input_gate_ovr_enable ? ovr.input_gate_ovr_value
                                            : 1'b1;
    return p;
  endfunction : resolve_pad

endpackage : altfn_pkg

// File: rtl/pad_sync.sv
// Two-flop synchroniser for pad inputs.
// Assumes asynchronous pad levels and one system clock.
`timescale 1ns/10ps
module pad_sync
  import altfn_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] pad_async,
  output logic      [WIDTH-1:0] pad_synced
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  always_comb begin
    state_next        = state_reg;
    state_next.stage1 = pad_async;
    state_next.stage2 = state_reg.stage1;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pad_synced = state_reg.stage2;

endmodule : pad_sync

// File: rtl/spike_filter.sv
// Spike filter: output follows input only after it has been stable.
// Assumes input already synchronised to clk_sys.
`timescale 1ns/10ps
module spike_filter
  import altfn_pkg::*;
#(
  parameter int unsigned STABLE_CYC = SPIKE_REJECT_CYC
) (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic raw_in,
  output logic      filt_out
);

  localparam int unsigned CW = $clog2(STABLE_CYC + 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic          level;
  } filt_state_t;

  filt_state_t state_reg;
  filt_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (raw_in == state_reg.level) begin
      state_next.count = '0;
    end else if (state_reg.count == CW'(STABLE_CYC - 1)) begin
      state_next.level = raw_in;
      state_next.count = '0;
    end else begin
      state_next.count = state_reg.count + CW'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg <= '{count: '0, level: 1'b1};
    end else begin
      state_reg <= state_next;
    end
  end

  assign filt_out = state_reg.level;

endmodule : spike_filter

// File: rtl/port_b_c_alt_function_override.sv
// Override logic for Port B pins 7..0 and Port C pins 6 and 5.
// Assumes port bits and unit signals arrive on clk_sys; pads are async.
`timescale 1ns/10ps
// Functional notes
// - SPI follower forces select pin to input
// - Follower active only while select is low
// - SPI leader leaves select direction alone
// - Forced-input select keeps port-bit pull-up
// - Match B on bit 2 needs direction out
// - Match A on bit 1 needs direction out
// - Match pins also carry PWM waveform
// - Bit 0 pad feeds timer 1 capture
// - On-chip RC selection overrides oscillator pin bit 6; bit 7 also needs outside clock
// - Bit 7 overridden to zero when conditions met
// - MISO/MOSI split into leader and follower paths
// - Bit 3 value ORs SPI and timer 2
// - Fuse programmed: bit C6 ordinary I/O
// - Fuse unprogrammed: bit C6 is reset pin
// - Reset-pin C6 reads direction, output, input zero
// - Two-wire enable takes C5 as clock line
// - Clock input filters 50 ns, open-drain out
// - Pull-up override value wins when enabled
// - Direction override value wins when enabled
// - Pin value override wins when driving
// - Global pull-up off disables every pull-up except reset-pin C6's, which stays on
module port_b_c_alt_function_override
  import altfn_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic [7:0]       portb_direction,
  input  wire logic [7:0]       portb_output_latch,
  input  wire logic [7:0]       portb_pad_in,
  output logic      [7:0]       portb_pad_out,
  output logic      [7:0]       portb_pad_oe,
  output logic      [7:0]       portb_pullup_on,
  output logic      [7:0]       portb_input_read,
  input  wire logic             portc_bit6_direction,
  input  wire logic             portc_bit6_output_latch,
  input  wire logic             portc_bit5_direction,
  input  wire logic             portc_bit5_output_latch,
  input  wire logic [1:0]       portc_pad_in,
  output logic      [1:0]       portc_pad_out,
  output logic      [1:0]       portc_pad_oe,
  output logic      [1:0]       portc_pullup_on,
  output logic                  portc_bit6_direction_read,
  output logic                  portc_bit6_output_read,
  output logic                  portc_bit6_input_read,
  output logic                  portc_bit5_input_read,
  output logic                  reset_pin_level,
  input  wire logic             global_pullup_off,
  input  wire spi_ctl_t         spi_ctl,
  output spi_in_t               spi_in,
  input  wire timer_ctl_t       timer_ctl,
  output logic                  timer1_capture_in,
  input  wire clk_cfg_t         clk_cfg,
  input  wire logic             two_wire_on,
  input  wire logic             two_wire_clock_out,
  output logic                  two_wire_clock_in
);

  typedef struct packed {
    logic [7:0] pb_out;
    logic [7:0] pb_oe;
    logic [7:0] pb_pu;
    logic [7:0] pb_rd;
    logic [1:0] pc_out;
    logic [1:0] pc_oe;
    logic [1:0] pc_pu;
    logic       c6_dir_rd;
    logic       c6_out_rd;
    logic       c6_in_rd;
    logic       c5_in_rd;
    logic       rst_lvl;
    spi_in_t    spi;
    logic       cap_in;
  } ovr_state_t;

  ovr_state_t state_reg;
  ovr_state_t state_next;

  logic [7:0] pb_sync;
  logic [1:0] pc_sync;
  logic       scl_filt;

  pad_sync #(
    .WIDTH (10)
  ) u_pad_sync (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .pad_async  ({portc_pad_in, portb_pad_in}),
    .pad_synced ({pc_sync, pb_sync})
  );

  spike_filter #(
    .STABLE_CYC (SPIKE_REJECT_CYC)
  ) u_scl_filter (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .raw_in   (pc_sync[0]),
    .filt_out (scl_filt)
  );

  pin_ovr_t [7:0] pb_ovr;
  pin_ovr_t [1:0] pc_ovr;
  logic           spi_follower;
  logic           spi_leader;
  logic           osc_ovr;
  logic           osc2_ovr;
  logic           pu_forced;

  always_comb begin
    pad_ctl_t pc;
    pc           = '0;
    state_next   = state_reg;
    pb_ovr       = '0;
    pc_ovr       = '0;
    spi_follower = spi_ctl.serial_periph_on && !spi_ctl.spi_leader_role;
    spi_leader   = spi_ctl.serial_periph_on && spi_ctl.spi_leader_role;
    osc_ovr      = clk_cfg.onchip_rc_selected
                || clk_cfg.timer2_async_select;
    osc2_ovr     = clk_cfg.outside_clock_selected && osc_ovr;
    pu_forced    = !global_pullup_off;

    // Oscillator pins: pull-up, driver and input forced off
    pb_ovr[PB_OSC2].pullup_ovr_enable     = osc2_ovr;
    pb_ovr[PB_OSC2].direction_ovr_enable  = osc2_ovr;
    pb_ovr[PB_OSC2].input_gate_ovr_enable = osc2_ovr;
    pb_ovr[PB_OSC1].pullup_ovr_enable     = osc_ovr;
    pb_ovr[PB_OSC1].direction_ovr_enable  = osc_ovr;
    pb_ovr[PB_OSC1].input_gate_ovr_enable = osc_ovr;

    // Clock pin: input in follower role, driven by SPI as leader
    pb_ovr[PB_SCK].pullup_ovr_enable    = spi_follower;
    pb_ovr[PB_SCK].pullup_ovr_value     =
      portb_output_latch[PB_SCK] && pu_forced;
    pb_ovr[PB_SCK].direction_ovr_enable = spi_follower;
    pb_ovr[PB_SCK].pin_value_ovr_enable = spi_leader;
    pb_ovr[PB_SCK].pin_value_ovr_value  = spi_ctl.sck_out;

    // MISO: input as leader, follower output path
    pb_ovr[PB_MISO].pullup_ovr_enable    = spi_leader;
    pb_ovr[PB_MISO].pullup_ovr_value     =
      portb_output_latch[PB_MISO] && pu_forced;
    pb_ovr[PB_MISO].direction_ovr_enable = spi_leader;
    pb_ovr[PB_MISO].pin_value_ovr_enable = spi_follower;
    pb_ovr[PB_MISO].pin_value_ovr_value  =
      spi_ctl.follower_data_out;

    // MOSI / timer 2 match
    pb_ovr[PB_MOSI].pullup_ovr_enable    = spi_follower;
    pb_ovr[PB_MOSI].pullup_ovr_value     =
      portb_output_latch[PB_MOSI] && pu_forced;
    pb_ovr[PB_MOSI].direction_ovr_enable = spi_follower;
    pb_ovr[PB_MOSI].pin_value_ovr_enable =
      spi_leader || timer_ctl.timer2_match_en;
    pb_ovr[PB_MOSI].pin_value_ovr_value  =
      (spi_leader && spi_ctl.leader_data_out)
      || (timer_ctl.timer2_match_en
          && timer_ctl.timer2_match_out);

    // Select pin / timer 1 match B
    pb_ovr[PB_SELECT].pullup_ovr_enable    = spi_follower;
    pb_ovr[PB_SELECT].pullup_ovr_value     =
      portb_output_latch[PB_SELECT] && pu_forced;
    pb_ovr[PB_SELECT].direction_ovr_enable = spi_follower;
    pb_ovr[PB_SELECT].direction_ovr_value  = 1'b0;
    pb_ovr[PB_SELECT].pin_value_ovr_enable =
      timer_ctl.timer1_match_b_en;
    pb_ovr[PB_SELECT].pin_value_ovr_value  =
      timer_ctl.timer1_match_b_out;

    // Timer 1 match A
    pb_ovr[PB_MATCH_A].pin_value_ovr_enable =
      timer_ctl.timer1_match_a_en;
    pb_ovr[PB_MATCH_A].pin_value_ovr_value  =
      timer_ctl.timer1_match_a_out;

    // Port C bit 6: reset pin unless the fuse is programmed
    pc_ovr[1].pullup_ovr_enable     = !clk_cfg.reset_pin_disable_fuse;
    pc_ovr[1].pullup_ovr_value      = 1'b1;
    pc_ovr[1].direction_ovr_enable  = !clk_cfg.reset_pin_disable_fuse;
    pc_ovr[1].input_gate_ovr_enable = !clk_cfg.reset_pin_disable_fuse;

    // Port C bit 5: two-wire clock, open drain
    pc_ovr[0].pullup_ovr_enable    = two_wire_on;
    pc_ovr[0].pullup_ovr_value     =
      portc_bit5_output_latch && pu_forced;
    pc_ovr[0].direction_ovr_enable = two_wire_on;
    pc_ovr[0].direction_ovr_value  = !two_wire_clock_out;
    pc_ovr[0].pin_value_ovr_enable = two_wire_on;
    pc_ovr[0].pin_value_ovr_value  = 1'b0;

    for (int i = 0; i < PORTB_WIDTH; i++) begin
      pc = resolve_pad(pb_ovr[i], portb_direction[i],
                       portb_output_latch[i],
                       global_pullup_off);
      state_next.pb_out[i] = pc.drive_val;
      state_next.pb_oe[i]  = pc.drive_en;
      state_next.pb_pu[i]  = pc.pullup_on;
      state_next.pb_rd[i]  = pc.input_en && pb_sync[i];
    end

    pc = resolve_pad(pc_ovr[1], portc_bit6_direction,
                     portc_bit6_output_latch, global_pullup_off);
    state_next.pc_out[1] = pc.drive_val;
    state_next.pc_oe[1]  = pc.drive_en;
    state_next.pc_pu[1]  = pc.pullup_on;
    state_next.c6_in_rd  = pc.input_en && pc_sync[1];
    state_next.c6_dir_rd = clk_cfg.reset_pin_disable_fuse
                         && portc_bit6_direction;
    state_next.c6_out_rd = clk_cfg.reset_pin_disable_fuse
                         && portc_bit6_output_latch;
    // Only when the pin is the reset pin does it reach reset circuitry
    state_next.rst_lvl   = clk_cfg.reset_pin_disable_fuse
                         || pc_sync[1];

    pc = resolve_pad(pc_ovr[0], portc_bit5_direction,
                     portc_bit5_output_latch, global_pullup_off);
    state_next.pc_out[0] = pc.drive_val;
    state_next.pc_oe[0]  = pc.drive_en;
    state_next.pc_pu[0]  = pc.pullup_on;
    state_next.c5_in_rd  = pc_sync[0];

    // Inputs to the units
    state_next.spi.sck_in           = pb_sync[PB_SCK];
    state_next.spi.leader_data_in   = pb_sync[PB_MISO];
    state_next.spi.follower_data_in = pb_sync[PB_MOSI];
    state_next.spi.select_active    =
      spi_follower && !pb_sync[PB_SELECT];
    state_next.cap_in               = pb_sync[PB_CAPTURE];
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg         <= '0;
      state_reg.rst_lvl <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign portb_pad_out             = state_reg.pb_out;
  assign portb_pad_oe              = state_reg.pb_oe;
  assign portb_pullup_on           = state_reg.pb_pu;
  assign portb_input_read          = state_reg.pb_rd;
  assign portc_pad_out             = state_reg.pc_out;
  assign portc_pad_oe              = state_reg.pc_oe;
  assign portc_pullup_on           = state_reg.pc_pu;
  assign portc_bit6_direction_read = state_reg.c6_dir_rd;
  assign portc_bit6_output_read    = state_reg.c6_out_rd;
  assign portc_bit6_input_read     = state_reg.c6_in_rd;
  assign portc_bit5_input_read     = state_reg.c5_in_rd;
  assign reset_pin_level           = state_reg.rst_lvl;
  assign spi_in                    = state_reg.spi;
  assign timer1_capture_in         = state_reg.cap_in;
  assign two_wire_clock_in         = two_wire_on ? scl_filt : 1'b1;

endmodule : port_b_c_alt_function_override

// File: tb/altfn_checker_assertions.sv
// Checker: override relations seen at the override block's ports.
// Assumes one clock, sync reset, and a bind by port name.
`timescale 1ns/10ps
module altfn_checker
  import altfn_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic [7:0] portb_direction,
  input wire logic [7:0] portb_output_latch,
  input wire logic [7:0] portb_pad_in,
  input wire logic [7:0] portb_pad_out,
  input wire logic [7:0] portb_pad_oe,
  input wire logic [7:0] portb_pullup_on,
  input wire logic [7:0] portb_input_read,
  input wire logic [1:0] portc_pad_in,
  input wire logic       portc_bit5_input_read,
  input wire logic       portc_bit6_direction,
  input wire logic [1:0] portc_pad_out,
  input wire logic [1:0] portc_pad_oe,
  input wire logic [1:0] portc_pullup_on,
  input wire logic       portc_bit6_direction_read,
  input wire logic       portc_bit6_output_read,
  input wire logic       portc_bit6_input_read,
  input wire logic       global_pullup_off,
  input wire spi_ctl_t   spi_ctl,
  input wire spi_in_t    spi_in,
  input wire timer_ctl_t timer_ctl,
  input wire logic       timer1_capture_in,
  input wire clk_cfg_t   clk_cfg,
  input wire logic       two_wire_on,
  input wire logic       two_wire_clock_out,
  input wire logic       two_wire_clock_in
);
  logic [1:0] age_reg;
  logic       follower, leader, osc_ovr;
  assign follower = spi_ctl.serial_periph_on && !spi_ctl.spi_leader_role;
  assign leader   = spi_ctl.serial_periph_on && spi_ctl.spi_leader_role;
  assign osc_ovr  = clk_cfg.onchip_rc_selected || clk_cfg.timer2_async_select;

  // Edges since reset, for the three-flop pad path
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      age_reg <= 2'h0;
    end else if (age_reg != 2'h3) begin
      age_reg <= age_reg + 2'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_follower_inputs: assert property (
    follower |=> (portb_pad_oe & 8'h2c) == 8'h00) else $error("follower pin driven");
  a_leader_select: assert property (
    leader |=> portb_pad_oe[2] == $past(portb_direction[2]) && !portb_pad_oe[4])
    else $error("leader pin directions wrong");
  a_select_pullup: assert property (
    follower |=> portb_pullup_on[2] ==
    ($past(portb_output_latch[2]) && !$past(global_pullup_off))) else $error("select pullup wrong");
  a_match_b_pin: assert property (
    timer_ctl.timer1_match_b_en && !follower |=> portb_pad_out[2] ==
    $past(timer_ctl.timer1_match_b_out) && portb_pad_oe[2] == $past(portb_direction[2]))
    else $error("match b pin wrong");
  a_match_a_pin: assert property (
    timer_ctl.timer1_match_a_en |=> portb_pad_out[1] == $past(timer_ctl.timer1_match_a_out)
    && portb_pad_oe[1] == $past(portb_direction[1])) else $error("match a pin wrong");
  a_mosi_or: assert property (
    leader && timer_ctl.timer2_match_en |=> portb_pad_out[3] ==
    ($past(spi_ctl.leader_data_out) || $past(timer_ctl.timer2_match_out)))
    else $error("bit 3 value wrong");
  a_pad_paths: assert property (
    age_reg == 2'h3 |-> timer1_capture_in == $past(portb_pad_in[0], 3) &&
    spi_in.leader_data_in == $past(portb_pad_in[4], 3) &&
    spi_in.follower_data_in == $past(portb_pad_in[3], 3)) else $error("pad path wrong");
  a_read_paths: assert property (
    age_reg == 2'h3 |-> spi_in.sck_in == $past(portb_pad_in[5], 3) &&
    portb_input_read[5:0] == $past(portb_pad_in[5:0], 3) &&
    portc_bit5_input_read == $past(portc_pad_in[0], 3))
    else $error("read path wrong");
  a_osc1_off: assert property (
    osc_ovr |=> !portb_pad_oe[6] && !portb_pullup_on[6] && !portb_input_read[6])
    else $error("bit 6 not released");
  a_osc2_off: assert property (
    osc_ovr && clk_cfg.outside_clock_selected |=> !portb_pad_oe[7] &&
    !portb_pullup_on[7] && !portb_input_read[7]) else $error("bit 7 not released");
  a_global_pullup: assert property (
    global_pullup_off |=> portb_pullup_on[1:0] == 2'h0) else $error("pullup not off");
  a_reset_pin_reads: assert property (
    !clk_cfg.reset_pin_disable_fuse |=> !portc_bit6_direction_read &&
    !portc_bit6_output_read && !portc_bit6_input_read && !portc_pad_oe[1] &&
    portc_pullup_on[1]) else $error("reset pin not isolated");
  a_io_pin_c6: assert property (
    clk_cfg.reset_pin_disable_fuse |=> portc_bit6_direction_read ==
    $past(portc_bit6_direction) && portc_pad_oe[1] == $past(portc_bit6_direction))
    else $error("bit c6 not ordinary");
  a_clock_open_drain: assert property (
    two_wire_on |=> !portc_pad_out[0] && portc_pad_oe[0] == !$past(two_wire_clock_out))
    else $error("clock line driven high");
  a_clock_idle: assert property (
    !two_wire_on [*2] |-> two_wire_clock_in) else $error("clock input not idle");

  c_follower: cover property (follower ##1 spi_in.select_active);
  c_match_b: cover property (timer_ctl.timer1_match_b_en && portb_pad_oe[2]);
  c_clock_low: cover property (two_wire_on && !two_wire_clock_in);
endmodule : altfn_checker

bind port_b_c_alt_function_override altfn_checker altfn_checker_i (
  .clk_sys, .sys_rst, .portb_direction, .portb_output_latch, .portb_pad_in,
  .portb_pad_out, .portb_pad_oe, .portb_pullup_on, .portb_input_read,
  .portc_bit6_direction, .portc_pad_out, .portc_pad_oe, .portc_pullup_on,
  .portc_bit6_direction_read, .portc_bit6_output_read, .portc_bit6_input_read,
  .portc_pad_in, .portc_bit5_input_read,
  .global_pullup_off, .spi_ctl, .spi_in, .timer_ctl, .timer1_capture_in,
  .clk_cfg, .two_wire_on, .two_wire_clock_out, .two_wire_clock_in);

// File: tb/unit_model.sv
// Partner: SPI and timer units feeding the override block.
// Assumes mode bits from the bench; waveforms run from a counter.
`timescale 1ns/10ps
module unit_model
  import altfn_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic [4:0] mode,
  output spi_ctl_t        spi_ctl,
  output timer_ctl_t      timer_ctl
);
  logic [3:0] wave_reg;

  // Shared counter makes the shift and PWM waveforms
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wave_reg <= 4'h0;
    end else begin
      wave_reg <= wave_reg + 4'h1;
    end
  end

  // Mode: on, leader, match A, match B, timer 2 from bit 0 up
  assign spi_ctl = '{mode[0], mode[1], wave_reg[0], wave_reg[1], wave_reg[2]};
  assign timer_ctl = '{mode[2], wave_reg < 4'h5, mode[3], wave_reg[3],
                       mode[4], wave_reg < 4'ha};
endmodule : unit_model

// File: tb/tb.sv
// Testbench: random and corner stimulus for the port override block.
// Assumes the override block, its bound checker and the unit model.
`timescale 1ns/10ps
module tb
  import altfn_pkg::*;
;
  logic       clk_sys = 1'h0;
  logic       sys_rst = 1'h1;
  logic [7:0] portb_direction, portb_output_latch, portb_pad_in;
  logic [7:0] portb_pad_out, portb_pad_oe, portb_pullup_on, portb_input_read;
  logic [1:0] portc_pad_in, portc_pad_out, portc_pad_oe, portc_pullup_on;
  logic       portc_bit6_direction, portc_bit6_output_latch;
  logic       portc_bit5_direction, portc_bit5_output_latch;
  logic       portc_bit6_direction_read, portc_bit6_output_read;
  logic       portc_bit6_input_read, portc_bit5_input_read, reset_pin_level;
  logic       global_pullup_off, two_wire_on, two_wire_clock_out;
  logic       two_wire_clock_in, timer1_capture_in, low, seen;
  logic [4:0] mode;
  spi_ctl_t   spi_ctl;
  spi_in_t    spi_in;
  timer_ctl_t timer_ctl;
  clk_cfg_t   clk_cfg;
  int         miscompares = 0;
  int         tests_run = 0;
  int         plen[3] = '{1, 6, 20};
  wire logic [3:0] c6_view = {portc_bit6_direction_read, portc_bit6_output_read,
                              portc_bit6_input_read, reset_pin_level};

  port_b_c_alt_function_override port_b_c_alt_function_override_i (
    .clk_sys, .sys_rst, .portb_direction, .portb_output_latch, .portb_pad_in,
    .portb_pad_out, .portb_pad_oe, .portb_pullup_on, .portb_input_read,
    .portc_bit6_direction, .portc_bit6_output_latch, .portc_bit5_direction,
    .portc_bit5_output_latch, .portc_pad_in, .portc_pad_out, .portc_pad_oe,
    .portc_pullup_on, .portc_bit6_direction_read, .portc_bit6_output_read,
    .portc_bit6_input_read, .portc_bit5_input_read, .reset_pin_level,
    .global_pullup_off, .spi_ctl, .spi_in, .timer_ctl, .timer1_capture_in,
    .clk_cfg, .two_wire_on, .two_wire_clock_out, .two_wire_clock_in);
  unit_model unit_model_i (.clk_sys, .sys_rst, .mode, .spi_ctl, .timer_ctl);

  always #4 clk_sys = ~clk_sys;

  function automatic logic exp_select(input logic [4:0] m, input logic pad);
    return m[0] && !m[1] && !pad;
  endfunction : exp_select

  // Read-backs and reset level of bit C6
  function automatic logic [3:0] exp_c6(input logic fuse, input logic pad);
    return fuse ? {2'h3, pad, 1'h1} : {3'h0, pad};
  endfunction : exp_c6

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : step

  task automatic shake();
    @(negedge clk_sys);
    {portb_direction, portb_output_latch, portb_pad_in} = 24'($urandom);
    {mode, portc_pad_in, global_pullup_off, two_wire_on} = 9'($urandom);
    {portc_bit6_direction, portc_bit6_output_latch} = 2'($urandom);
    {portc_bit5_direction, portc_bit5_output_latch} = 2'($urandom);
    {two_wire_clock_out, clk_cfg} = 5'($urandom);
  endtask : shake

  task automatic finish_test();
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    {portb_direction, portb_output_latch, portb_pad_in, mode} = '0;
    {portc_pad_in, portc_bit6_direction, portc_bit6_output_latch} = '0;
    {portc_bit5_direction, portc_bit5_output_latch, global_pullup_off} = '0;
    {two_wire_on, two_wire_clock_out, clk_cfg} = '0;
    void'($urandom(32'ha2f3_e22d));
    step(5);
    sys_rst = 1'h0;
    repeat (1000) shake();
    $display("test random done");
    for (int i = 0; i < 4; i++) begin
      mode = {3'h0, i[1], 1'h1};
      portb_pad_in[2] = i[0];
      step(4);
      cmp(spi_in.select_active, exp_select(mode, i[0]));
    end
    $display("test select done");
    two_wire_on = 1'h1;
    portc_pad_in[0] = 1'h1;
    step(20);
    foreach (plen[k]) begin
      seen = 1'h1;
      portc_pad_in[0] = 1'h0;
      step(plen[k]);
      low = two_wire_clock_in;
      portc_pad_in[0] = 1'h1;
      repeat (12) begin
        step(1);
        seen &= two_wire_clock_in;
      end
      cmp({low, seen}, plen[k] < SPIKE_REJECT_CYC ? 2'h3 : 2'h0);
    end
    $display("test spike done");
    {portc_bit6_direction, portc_bit6_output_latch} = 2'h3;
    for (int i = 0; i < 4; i++) begin
      clk_cfg.reset_pin_disable_fuse = i[1];
      portc_pad_in[1] = i[0];
      step(4);
      cmp(c6_view, exp_c6(i[1], i[0]));
    end
    $display("test reset pin done");
    repeat (300) shake();
    sys_rst = 1'h1;
    step(2);
    // Reset values: levels high, drivers off
    cmp({reset_pin_level, two_wire_clock_in, portc_pad_oe, portb_pad_oe},
        12'hc00);
    sys_rst = 1'h0;
    repeat (500) shake();
    $display("test second reset done");
    finish_test();
  end

  initial begin
    repeat (10000) @(posedge clk_sys);
    miscompares++;
    finish_test();
  end
endmodule : tb
